// ==== hpsc_slot.v ====
// Purpose: hot-plug slot control and status registers of a downstream port
// Assumes: slot inputs synchronous to REF_CLK, one-cycle event pulses
// Notes: one wait state on every access; unmapped reads return zero
`timescale 1ns/1ps
`include "hpsc_map.vh"

// How it works
// - bit0 enables attention button event
// - bit1 enables power fault event
// - bit3 enables presence change event
// - bit4 enables command completed interrupt
// - bit5 master hot-plug interrupt enable
// - bits7:6 attention indicator, reset off
// - attention field write sends message
// - bits9:8 power indicator, reset off
// - power indicator write sends message
// - bit10 slot power, 1 is off
// - bit12 enables link-active change notice
// - bit16 latches button press, W1C
// - bit17 latches power fault, W1C
// - bit18 read-only retention latch change
// - bit19 latches presence change, W1C
// - bit20 latches command completion, W1C
// - bit21 shows retention latch state
// - bit22 shows card presence
// - no slot implemented reads present
// - presence resets from inverted strap
// - bit24 sets on link-active change
// - link-active reads 1 in active state
module hpsc_slot (
    input wire REF_CLK,
    input wire RESET_N,
    input wire [7:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [3:0] AVS_BYTEENABLE,
    output reg [31:0] AVS_READDATA,
    output reg AVS_WAITREQUEST,
    input wire SLOT_IMPLEMENTED,
    input wire CARD_PRESENT_STRAP,
    input wire CARD_PRESENT,
    input wire ATTN_BUTTON_PRESS,
    input wire POWER_FAULT,
    input wire RETENTION_LATCH_OPEN,
    input wire DL_ACTIVE,
    output reg [1:0] ATTN_IND,
    output reg [1:0] PWR_IND,
    output reg PWR_OFF,
    output reg ATTN_MSG,
    output reg PWR_IND_MSG,
    output reg HP_IRQ
);

    reg abp_en_r, pf_en_r, pd_en_r, cc_en_r, hp_en_r, dll_en_r;
    reg abp_r, pf_r, rlc_r, pdc_r, cc_r, dllsc_r;
    reg rls_r, pds_r, link_act_r, strap_done_r;
    reg [3:0] cmd_cnt_r;
    reg ack_r;
    wire req;
    wire wr_slot;
    wire rd_hit;
    wire ctl_wr_lo;
    wire ctl_wr_hi;
    wire st_wr;
    wire st_wr_hi;
    wire pres_now;
    wire [31:0] slot_word;
    wire [31:0] link_word;
    wire [31:0] rd_mux;
    wire irq_nxt;

    function hit;
        input [7:0] a;
        input [7:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    // one wait state: waitrequest drops in the cycle after the request
    assign req = (AVS_READ | AVS_WRITE) & ~ack_r;
    assign wr_slot = AVS_WRITE & ack_r & hit(AVS_ADDRESS, `HPSC_OFS_SLOT);
    assign rd_hit = AVS_READ & ~ack_r;
    assign ctl_wr_lo = wr_slot & AVS_BYTEENABLE[0];
    assign ctl_wr_hi = wr_slot & AVS_BYTEENABLE[1];
    assign st_wr = wr_slot & AVS_BYTEENABLE[2];
    // bit24 lives in lane3, so its write-one clear needs that lane
    assign st_wr_hi = wr_slot & AVS_BYTEENABLE[3];

    assign pres_now = SLOT_IMPLEMENTED ? CARD_PRESENT : 1'b1;

    assign slot_word = {7'h00, dllsc_r, 1'b0, pds_r, rls_r, cc_r, pdc_r,
        rlc_r, pf_r, abp_r, 3'h0, dll_en_r, 1'b0, PWR_OFF, PWR_IND,
        ATTN_IND, hp_en_r, cc_en_r, pd_en_r, 1'b0, pf_en_r, abp_en_r};
    assign link_word = {2'h0, link_act_r, 29'h0000000};
    assign rd_mux = hit(AVS_ADDRESS, `HPSC_OFS_SLOT) ? slot_word :
        hit(AVS_ADDRESS, `HPSC_OFS_LINK) ? link_word : 32'h00000000;

    assign irq_nxt = hp_en_r & ((abp_r & abp_en_r) | (pf_r & pf_en_r) |
        (pdc_r & pd_en_r) | (cc_r & cc_en_r) | (dllsc_r & dll_en_r));

    always @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_r <= 1'b0;
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h00000000;
        end else begin
            ack_r <= req;
            AVS_WAITREQUEST <= ~req;
            if (rd_hit) begin
                AVS_READDATA <= rd_mux;
            end
        end
    end

    always @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            abp_en_r <= 1'b0;
            pf_en_r <= 1'b0;
            pd_en_r <= 1'b0;
            cc_en_r <= 1'b0;
            hp_en_r <= 1'b0;
            dll_en_r <= 1'b0;
            ATTN_IND <= `HPSC_IND_OFF;
            PWR_IND <= `HPSC_IND_OFF;
            PWR_OFF <= 1'b0;
            ATTN_MSG <= 1'b0;
            PWR_IND_MSG <= 1'b0;
            cmd_cnt_r <= `HPSC_CMD_ZERO;
        end else begin
            ATTN_MSG <= 1'b0;
            PWR_IND_MSG <= 1'b0;
            if (ctl_wr_lo) begin
                abp_en_r <= AVS_WRITEDATA[`HPSC_B_ABP_EN];
                pf_en_r <= AVS_WRITEDATA[`HPSC_B_PF_EN];
                pd_en_r <= AVS_WRITEDATA[`HPSC_B_PD_EN];
                cc_en_r <= AVS_WRITEDATA[`HPSC_B_CC_EN];
                hp_en_r <= AVS_WRITEDATA[`HPSC_B_HP_EN];
                ATTN_IND <= AVS_WRITEDATA[`HPSC_B_ATTN_HI:`HPSC_B_ATTN_LO];
                ATTN_MSG <= 1'b1;
            end
            if (ctl_wr_hi) begin
                PWR_IND <= AVS_WRITEDATA[`HPSC_B_PWRI_HI:`HPSC_B_PWRI_LO];
                PWR_IND_MSG <= 1'b1;
                PWR_OFF <= AVS_WRITEDATA[`HPSC_B_PWR_CTL];
                dll_en_r <= AVS_WRITEDATA[`HPSC_B_DLL_EN];
            end
            // any control write is a command; it completes after a delay
            if (ctl_wr_lo | ctl_wr_hi) begin
                cmd_cnt_r <= `HPSC_CMD_CYC;
            end else if (cmd_cnt_r != `HPSC_CMD_ZERO) begin
                cmd_cnt_r <= cmd_cnt_r - `HPSC_CMD_ONE;
            end
        end
    end

    always @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            abp_r <= 1'b0;
            pf_r <= 1'b0;
            rlc_r <= 1'b0;
            pdc_r <= 1'b0;
            cc_r <= 1'b0;
            dllsc_r <= 1'b0;
            rls_r <= 1'b0;
            pds_r <= 1'b0;
            link_act_r <= 1'b0;
            strap_done_r <= 1'b0;
            HP_IRQ <= 1'b0;
        end else begin
            // set wins over a same-cycle write-one clear
            // button latch
            abp_r <= ATTN_BUTTON_PRESS |
                (abp_r & ~(st_wr & AVS_WRITEDATA[`HPSC_B_ABP]));
            pf_r <= POWER_FAULT |
                (pf_r & ~(st_wr & AVS_WRITEDATA[`HPSC_B_PF]));
            rlc_r <= rlc_r | (RETENTION_LATCH_OPEN != rls_r);
            rls_r <= RETENTION_LATCH_OPEN;
            if (!strap_done_r) begin
                strap_done_r <= 1'b1;
                pds_r <= ~CARD_PRESENT_STRAP;
            end else begin
                pds_r <= pres_now;
            end
            pdc_r <= (strap_done_r & (pres_now != pds_r)) |
                (pdc_r & ~(st_wr & AVS_WRITEDATA[`HPSC_B_PDC]));
            cc_r <= (cmd_cnt_r == `HPSC_CMD_ONE) |
                (cc_r & ~(st_wr & AVS_WRITEDATA[`HPSC_B_CC]));
            link_act_r <= DL_ACTIVE;
            dllsc_r <= (DL_ACTIVE != link_act_r) |
                (dllsc_r & ~(st_wr_hi & AVS_WRITEDATA[`HPSC_B_DLLSC]));
            HP_IRQ <= irq_nxt;
        end
    end

endmodule

// ==== hpsc_map.vh ====
// Purpose: constants for the hot-plug slot control and status block
// Assumes: slot word at byte offset D8h, link word at DCh, Avalon-MM slave
// Notes: control in bits 15:0, status in bits 31:16
`ifndef HPSC_MAP_VH
`define HPSC_MAP_VH

`define HPSC_ADDR_W 8
`define HPSC_OFS_SLOT 8'hD8
`define HPSC_OFS_LINK 8'hDC

`define HPSC_B_ABP_EN 0
`define HPSC_B_PF_EN 1
`define HPSC_B_PD_EN 3
`define HPSC_B_CC_EN 4
`define HPSC_B_HP_EN 5
`define HPSC_B_ATTN_LO 6
`define HPSC_B_ATTN_HI 7
`define HPSC_B_PWRI_LO 8
`define HPSC_B_PWRI_HI 9
`define HPSC_B_PWR_CTL 10
`define HPSC_B_DLL_EN 12

`define HPSC_B_ABP 16
`define HPSC_B_PF 17
`define HPSC_B_RLC 18
`define HPSC_B_PDC 19
`define HPSC_B_CC 20
`define HPSC_B_RLS 21
`define HPSC_B_PDS 22
`define HPSC_B_DLLSC 24
`define HPSC_B_LINK_ACT 29

`define HPSC_IND_OFF 2'h3
`define HPSC_CMD_CYC 4'h8
`define HPSC_CMD_ZERO 4'h0
`define HPSC_CMD_ONE 4'h1

`endif

// ==== hpsc_chk_sva.sv ====
// Purpose: port checks for hpsc_slot
// Assumes: bound from tb_top
// Notes: an access is the cycle with waitrequest low
`timescale 1ns/1ps
module hpsc_chk (
    input wire REF_CLK,
    input wire RESET_N,
    input wire [7:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [3:0] AVS_BYTEENABLE,
    input wire [31:0] AVS_READDATA,
    input wire AVS_WAITREQUEST,
    input wire [1:0] ATTN_IND,
    input wire [1:0] PWR_IND,
    input wire PWR_OFF,
    input wire ATTN_MSG,
    input wire PWR_IND_MSG
);
    wire [31:0] wd = AVS_WRITEDATA;
    wire acc = !AVS_WAITREQUEST && AVS_ADDRESS == 8'hD8;
    wire wr0 = acc && AVS_WRITE && AVS_BYTEENABLE[0];
    wire wr1 = acc && AVS_WRITE && AVS_BYTEENABLE[1];
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    a_attn_msg: assert property (wr0 |=> ATTN_MSG ##1 !ATTN_MSG)
        else $error("attention message pulse wrong");
    a_msg_cause: assert property (ATTN_MSG |-> $past(wr0))
        else $error("attention message without write");
    a_pwr_msg: assert property (wr1 |=> PWR_IND_MSG ##1 !PWR_IND_MSG)
        else $error("power message pulse wrong");
    a_attn_val: assert property (wr0 |=> ATTN_IND == $past(wd[7:6]))
        else $error("attention indicator wrong");
    a_attn_hold: assert property (!wr0 |=> $stable(ATTN_IND))
        else $error("attention indicator moved");
    a_pwr_ind: assert property (wr1 |=> PWR_IND == $past(wd[9:8]))
        else $error("power indicator wrong");
    a_pwr_off: assert property (wr1 |=> PWR_OFF == $past(wd[10]))
        else $error("power control wrong");
    a_rsvd_zero: assert property (acc && AVS_READ |->
        (AVS_READDATA & 32'hFE80E804) == 32'h0)
        else $error("reserved bit reads one");
    c_write: cover property (wr0 && wr1);
    c_read: cover property (acc && AVS_READ);
    c_pwr_off: cover property (PWR_OFF);
endmodule

// ==== hpsc_mdl.sv ====
// Purpose: behavioural hot-plug slot
// Assumes: bench requests events one cycle at a time
// Notes: pulses last one cycle, levels toggle per request
`timescale 1ns/1ps
module hpsc_mdl (
    input wire clk,
    input wire [4:0] ev,
    output reg btn,
    output reg flt,
    output reg card,
    output reg latch_open,
    output reg dl
);
    initial {btn, flt, card, latch_open, dl} = 5'h04;
    always @(posedge clk) begin
        btn <= ev[0];
        flt <= ev[1];
        card <= card ^ ev[2];
        latch_open <= latch_open ^ ev[3];
        dl <= dl ^ ev[4];
    end
endmodule

// ==== tb_top.sv ====
// Purpose: self-checking bench for hpsc_slot
// Assumes: one access at a time, expected reads queued
// Notes: strap tied low, so presence starts set
`timescale 1ns/1ps
module tb_top;
    reg REF_CLK = 0, RESET_N = 0, AVS_READ = 0, AVS_WRITE = 0;
    reg SLOT_IMPLEMENTED = 1, CARD_PRESENT_STRAP = 0;
    reg [7:0] AVS_ADDRESS = 8'h00;
    reg [31:0] AVS_WRITEDATA = 32'h0;
    reg [3:0] AVS_BYTEENABLE = 4'h0;
    reg [4:0] ev = 5'h00;
    wire [31:0] AVS_READDATA;
    wire [1:0] ATTN_IND, PWR_IND;
    wire AVS_WAITREQUEST, CARD_PRESENT, ATTN_BUTTON_PRESS, POWER_FAULT;
    wire RETENTION_LATCH_OPEN, DL_ACTIVE, ATTN_MSG, PWR_IND_MSG;
    wire HP_IRQ, PWR_OFF;
    int miscompares = 0, checks_done = 0, cyc = 0;
    logic [31:0] exp_q[$], msk_q[$];
    logic [15:0] lf = 16'h6FBD;
    hpsc_slot uut (.*);
    hpsc_mdl mdl (.clk(REF_CLK), .ev(ev), .btn(ATTN_BUTTON_PRESS),
        .flt(POWER_FAULT), .card(CARD_PRESENT),
        .latch_open(RETENTION_LATCH_OPEN), .dl(DL_ACTIVE));
    always #10 REF_CLK = ~REF_CLK;
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic summarize;
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] e, m, v);
        checks_done++;
        if ((v & m) !== (e & m)) begin
            miscompares++;
            $display("mismatch %s exp %h got %h", n, e & m, v & m);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] be);
        @(posedge REF_CLK);
        AVS_READ <= !w;
        AVS_WRITE <= w;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_BYTEENABLE <= be;
        do @(posedge REF_CLK); while (AVS_WAITREQUEST !== 1'b0);
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        acc(1'b0, a, 32'h0, 4'hF);
    endtask
    // sampled at the edge, so read data match what the master takes
    always @(posedge REF_CLK) begin
        cyc <= cyc + 1;
        if (AVS_READ && !AVS_WAITREQUEST && exp_q.size() > 0)
            cmp("readdata", exp_q.pop_front(), msk_q.pop_front(),
                AVS_READDATA);
        if (cyc == 3000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        logic [15:0] c;
        repeat (12) @(posedge REF_CLK);
        RESET_N <= 1'b1;
        rd(8'hD8, 32'h004003C0, 32'hFFFFFFFF);
        repeat (3) begin
            lf = lfsr_next(lf);
            c = lf & 16'h17FB | 16'h0140;
            acc(1'b1, 8'hD8, {16'h0, c}, 4'h3);
            repeat (10) @(posedge REF_CLK);
            rd(8'hD8, {16'h0050, c}, 32'h01FFFFFF);
            @(negedge REF_CLK);
            cmp("hp_irq", {31'h0, c[5] & c[4]}, 32'h1, {31'h0, HP_IRQ});
        end
        acc(1'b1, 8'hD8, 32'h000013FB, 4'h3);
        ev <= 5'h1F;
        @(posedge REF_CLK);
        ev <= 5'h00;
        repeat (12) @(posedge REF_CLK);
        rd(8'hD8, 32'h013F13FB, 32'hFFFFFFFF);
        rd(8'hDC, 32'h20000000, 32'h20000000);
        rd(8'h40, 32'h0, 32'hFFFFFFFF);
        @(negedge REF_CLK);
        cmp("hp_irq", 32'h1, 32'h1, {31'h0, HP_IRQ});
        acc(1'b1, 8'hD8, 32'h011F0000, 4'hC);
        rd(8'hD8, 32'h002413FB, 32'hFFFFFFFF);
        @(negedge REF_CLK);
        cmp("hp_irq", 32'h0, 32'h1, {31'h0, HP_IRQ});
        SLOT_IMPLEMENTED <= 1'b0;
        rd(8'hD8, 32'h00400000, 32'h00400000);
        summarize();
    end
endmodule
bind hpsc_slot hpsc_chk chk (.*);
